// >>> hw/irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// R1: An accepted enabled request loads the program counter with its vector.
// R2: Non-maskable source uses vector ffc, set by falling edge on its pin.
// R3: Port A uses vector ff6, falling edge or low level selectable.
// R4: Port B uses vector ff4, falling or rising edge selectable.
// R5: Timer uses vector ff2; reserved vector ff0 is never raised.
// R6: Timer flag sets on timer event; forwarded only while its mask is one.
// R7: NMI preempts anything; maskables never nest; order port A, B, timer.
// R8: Option register at c8 is write only, whole byte, resets to zero.
// R9: Option bit 6 set makes port A low level sensitive.
// R10: Option bit 5 set makes port B rising edge sensitive.
// R11: Option bit 4 enables maskable sources; other bits unused.
// R12: With global enable clear, NMI still served but never wakes the core.
// R13: NMI falling edge latched; latch cleared when the NMI routine starts.
// R14: Edge mode keeps one extra edge during service; further edges are dropped.
// R15: Level mode stores nothing; pin sampled low at instruction boundary counts.
// R16: Requests are tested at each boundary; next instruction is then suppressed.
// R17: Separate flag sets for normal, interrupt and NMI; switched on entry.
// R18: Accepting pushes the current program counter before loading the vector.
// R19: During a maskable routine further maskables are blocked, NMI accepted.
// R20: Entry clears the first latch of the accepted source.
// R21: Return restores the previous flag set and pops the program counter.
// R22: After reset the core is in NMI mode until a return.
// R23: Wait and stop are refused while an enabled request is pending.
// R24: Each port request combines its individually enabled pins.
// R25: Software polls shared sources and clears the timer flag before return.
module irq_ctrl (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Avalon-MM slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Pins and timer
  input wire logic nmi_pin,
  input wire logic [5:0] porta_pins,
  input wire logic [5:0] portb_pins,
  input wire logic timer_event,
  // Core side
  input wire logic [11:0] core_pc,
  input wire logic core_sleeping,
  output logic vector_load,
  output logic [11:0] vector_addr,
  output logic stack_push,
  output logic [11:0] stack_push_data,
  output logic stack_pop,
  output logic suppress_next,
  output logic [1:0] flag_set_sel,
  output logic wake_up,
  output logic sleep_grant
);

  // ****************************************************************
  // State
  // ****************************************************************
  typedef enum logic [1:0] {MODE_NORMAL, MODE_IRQ, MODE_NMI} mode_e;
  mode_e mode_reg, mode_next, saved_mode_reg, saved_mode_next;

  logic [7:0] option_reg;
  logic [5:0] porta_en_reg, portb_en_reg;
  logic timer_flag_reg, timer_mask_reg;
  logic nmi_prev_reg, nmi_latch_reg;
  logic [5:0] porta_prev_reg, portb_prev_reg;
  logic [1:0] porta_cnt_reg, portb_cnt_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;

  // Combine enabled pins into one line per port, high when any is low
  function automatic logic port_low(input logic [5:0] pins, input logic [5:0] en);
    port_low = |(~pins & en);
  endfunction : port_low

  // Per-pin edge on enabled pins, so option or enable writes make no false edge
  function automatic logic port_edge(input logic [5:0] pins, input logic [5:0] prev,
                                     input logic [5:0] en, input logic rise);
    port_edge = |(en & (rise ? (pins & ~prev) : (~pins & prev)));
  endfunction : port_edge

  // Edge latch counter: first latch plus one stored extra, saturating
  function automatic logic [1:0] latch_step(input logic [1:0] cnt, input logic edge_in,
                                            input logic clr);
    logic [1:0] c;
    c = cnt;
    if (clr && c != 2'h0) begin
      c = c - 2'h1;
    end
    if (edge_in && c != 2'h2) begin
      c = c + 2'h1;
    end
    latch_step = c;
  endfunction : latch_step

  // ****************************************************************
  // Bus decode
  // ****************************************************************
  wire bus_req = (avs_read | avs_write) & ~ack_reg;
  // Writes act at the edge where waitrequest is low
  wire wr_go = avs_write & ack_reg;
  wire wr_option = wr_go && avs_address == irq_ctrl_pkg::OPTION_ADDR;
  wire wr_pa_en = wr_go && avs_address == irq_ctrl_pkg::PORTA_IRQ_EN_ADDR;
  wire wr_pb_en = wr_go && avs_address == irq_ctrl_pkg::PORTB_IRQ_EN_ADDR;
  wire wr_timer = wr_go && avs_address == irq_ctrl_pkg::TIMER_CTRL_ADDR;
  wire wr_core = wr_go && avs_address == irq_ctrl_pkg::CORE_CTRL_ADDR;
  wire boundary = wr_core && avs_writedata[irq_ctrl_pkg::CC_BOUNDARY_BIT];
  wire do_return = wr_core && avs_writedata[irq_ctrl_pkg::CC_RETURN_BIT];
  wire sleep_req = wr_core && avs_writedata[irq_ctrl_pkg::CC_SLEEP_BIT];

  // ****************************************************************
  // Option fields and request lines
  // ****************************************************************
  wire level_a = option_reg[irq_ctrl_pkg::OPT_LEVEL_A_BIT]; // R9
  wire rise_b = option_reg[irq_ctrl_pkg::OPT_RISE_B_BIT]; // R10
  wire gen = option_reg[irq_ctrl_pkg::OPT_GEN_BIT]; // R11
  wire porta_line = port_low(porta_pins, porta_en_reg); // R24
  wire nmi_edge = nmi_prev_reg & ~nmi_pin; // R2
  wire porta_edge = port_edge(porta_pins, porta_prev_reg, porta_en_reg, 1'b0); // R3
  wire portb_edge = port_edge(portb_pins, portb_prev_reg, portb_en_reg, rise_b); // R4 R10
  wire porta_req = level_a ? porta_line : (porta_cnt_reg != 2'h0); // R15 R3
  wire portb_req = portb_cnt_reg != 2'h0;
  wire timer_req = timer_flag_reg & timer_mask_reg; // R6
  wire mask_ok = gen && mode_reg == MODE_NORMAL; // R11 R19 R7
  wire take_nmi = boundary && nmi_latch_reg; // R7 R16
  wire take_a = boundary && !nmi_latch_reg && mask_ok && porta_req; // R7
  wire take_b = boundary && !nmi_latch_reg && mask_ok && !porta_req && portb_req;
  wire take_t = boundary && !nmi_latch_reg && mask_ok && !porta_req && !portb_req
                && timer_req;
  wire take_any = take_nmi | take_a | take_b | take_t;
  wire mask_pending = gen && (porta_req | portb_req | timer_req);
  wire any_pending = nmi_latch_reg | mask_pending; // R23
  wire wake_src = gen && (nmi_latch_reg | mask_pending); // R12

  // Vector of the accepted source; reserved vector is never selected
  wire [11:0] vec_sel = take_nmi ? irq_ctrl_pkg::NMI_VECTOR : // R2
                        take_a ? irq_ctrl_pkg::PORTA_VECTOR : // R3
                        take_b ? irq_ctrl_pkg::PORTB_VECTOR : // R4
                        irq_ctrl_pkg::TIMER_VECTOR; // R5

  // Read mux; option register is write only and reads zero
  wire [31:0] rd_mux =
    avs_address == irq_ctrl_pkg::PORTA_IRQ_EN_ADDR ? {26'h0, porta_en_reg} :
    avs_address == irq_ctrl_pkg::PORTB_IRQ_EN_ADDR ? {26'h0, portb_en_reg} :
    avs_address == irq_ctrl_pkg::TIMER_CTRL_ADDR ?
      {24'h0, timer_flag_reg, timer_mask_reg, 6'h0} :
    avs_address == irq_ctrl_pkg::STATUS_ADDR ?
      {24'h0, nmi_latch_reg, porta_req, portb_req, timer_req, any_pending, 1'b0,
       flag_set_sel} :
    32'h0; // R8

  // ****************************************************************
  // Mode sequencing
  // ****************************************************************
  always_comb begin
    mode_next = mode_reg;
    saved_mode_next = saved_mode_reg;
    if (take_nmi) begin
      saved_mode_next = mode_reg; // R17
      mode_next = MODE_NMI;
    end else if (take_a | take_b | take_t) begin
      saved_mode_next = MODE_NORMAL;
      mode_next = MODE_IRQ; // R19
    end else if (do_return) begin
      mode_next = (mode_reg == MODE_NMI) ? saved_mode_reg : MODE_NORMAL; // R21
      saved_mode_next = MODE_NORMAL;
    end
  end

  // Encoding of the flag set for the core
  function automatic logic [1:0] flag_code(input mode_e m);
    case (m)
      MODE_NORMAL: flag_code = irq_ctrl_pkg::FLAGSET_NORMAL;
      MODE_IRQ: flag_code = irq_ctrl_pkg::FLAGSET_IRQ;
      MODE_NMI: flag_code = irq_ctrl_pkg::FLAGSET_NMI;
      default: flag_code = irq_ctrl_pkg::FLAGSET_NORMAL;
    endcase
  endfunction : flag_code

  // ****************************************************************
  // Registers
  // ****************************************************************
  // Mode starts in NMI after reset
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      mode_reg <= MODE_NMI; // R22
      saved_mode_reg <= MODE_NORMAL;
    end else begin
      mode_reg <= mode_next;
      saved_mode_reg <= saved_mode_next;
    end
  end

  // Software registers; option written as a whole byte
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      option_reg <= irq_ctrl_pkg::OPTION_RESET; // R8
      porta_en_reg <= 6'h00;
      portb_en_reg <= 6'h00;
      timer_mask_reg <= 1'b0;
    end else begin
      if (wr_option) begin
        option_reg <= avs_writedata[7:0] & irq_ctrl_pkg::OPTION_USED_MASK; // R8 R11
      end
      if (wr_pa_en) begin
        porta_en_reg <= avs_writedata[5:0];
      end
      if (wr_pb_en) begin
        portb_en_reg <= avs_writedata[5:0];
      end
      if (wr_timer) begin
        timer_mask_reg <= avs_writedata[irq_ctrl_pkg::TMR_MASK_BIT];
      end
    end
  end

  // Timer flag: event wins over a software clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      timer_flag_reg <= 1'b0;
    end else if (timer_event) begin
      timer_flag_reg <= 1'b1; // R6
    end else if (wr_timer && !avs_writedata[irq_ctrl_pkg::TMR_FLAG_BIT]) begin
      timer_flag_reg <= 1'b0; // R25
    end
  end

  // NMI latch: a new edge wins over the entry clear
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      nmi_prev_reg <= 1'b1;
      nmi_latch_reg <= 1'b0;
    end else begin
      nmi_prev_reg <= nmi_pin;
      nmi_latch_reg <= nmi_edge | (nmi_latch_reg & ~take_nmi); // R13
    end
  end

  // Port edge latches: first latch plus one stored edge
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      porta_prev_reg <= 6'h3f;
      portb_prev_reg <= 6'h3f;
      porta_cnt_reg <= 2'h0;
      portb_cnt_reg <= 2'h0;
    end else begin
      porta_prev_reg <= porta_pins;
      portb_prev_reg <= portb_pins;
      porta_cnt_reg <= level_a ? 2'h0 : latch_step(porta_cnt_reg, porta_edge, take_a); // R14 R20 R15
      portb_cnt_reg <= latch_step(portb_cnt_reg, portb_edge, take_b); // R14 R20
    end
  end

  // Core outputs
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      vector_load <= 1'b0;
      vector_addr <= irq_ctrl_pkg::RESET_VECTOR;
      stack_push <= 1'b0;
      stack_push_data <= 12'h000;
      stack_pop <= 1'b0;
      suppress_next <= 1'b0;
      flag_set_sel <= irq_ctrl_pkg::FLAGSET_NMI;
      wake_up <= 1'b0;
      sleep_grant <= 1'b0;
    end else begin
      vector_load <= take_any; // R1
      stack_push <= take_any; // R18
      suppress_next <= take_any; // R16
      stack_pop <= do_return & ~take_any; // R21
      if (take_any) begin
        vector_addr <= vec_sel;
        stack_push_data <= core_pc; // R18
      end
      flag_set_sel <= flag_code(mode_next); // R17
      wake_up <= core_sleeping & wake_src; // R12
      sleep_grant <= sleep_req & ~any_pending; // R23
    end
  end

  // ****************************************************************
  // Bus slave: one wait cycle then acknowledge
  // ****************************************************************
  always_ff @(posedge clk_sys) begin
    if (!rstn) begin
      ack_reg <= 1'b0;
      rdata_reg <= 32'h0;
    end else begin
      ack_reg <= bus_req;
      rdata_reg <= bus_req ? rd_mux : 32'h0;
    end
  end

  assign avs_waitrequest = ~ack_reg;
  assign avs_readdata = rdata_reg;

endmodule : irq_ctrl
`default_nettype wire

// >>> hw/irq_ctrl_pkg.sv
package irq_ctrl_pkg;
  // ****************************************************************
  // Register map
  // ****************************************************************
  localparam logic [7:0] OPTION_ADDR = 8'hc8;
  localparam logic [7:0] OPTION_RESET = 8'h00;
  localparam logic [7:0] PORTA_IRQ_EN_ADDR = 8'hcc;
  localparam logic [7:0] PORTB_IRQ_EN_ADDR = 8'hcd;
  localparam logic [7:0] TIMER_CTRL_ADDR = 8'hd4;
  localparam logic [7:0] STATUS_ADDR = 8'he0;
  localparam logic [7:0] CORE_CTRL_ADDR = 8'he4;
  localparam logic [7:0] VECTOR_ADDR = 8'he8;
  localparam int BUS_AW = 8;
  // ****************************************************************
  // Option register fields
  // ****************************************************************
  localparam int OPT_LEVEL_A_BIT = 6;
  localparam int OPT_RISE_B_BIT = 5;
  localparam int OPT_GEN_BIT = 4;
  localparam logic [7:0] OPTION_USED_MASK = 8'h70;
  // Timer control fields
  localparam int TMR_FLAG_BIT = 7;
  localparam int TMR_MASK_BIT = 6;
  // Core control fields (write one pulses)
  localparam int CC_BOUNDARY_BIT = 0;
  localparam int CC_RETURN_BIT = 1;
  localparam int CC_SLEEP_BIT = 2;
  // ****************************************************************
  // Vectors and flag sets
  // ****************************************************************
  localparam logic [11:0] RESET_VECTOR = 12'hffe;
  localparam logic [11:0] NMI_VECTOR = 12'hffc;
  localparam logic [11:0] PORTA_VECTOR = 12'hff6;
  localparam logic [11:0] PORTB_VECTOR = 12'hff4;
  localparam logic [11:0] TIMER_VECTOR = 12'hff2;
  localparam logic [11:0] RESERVED_VECTOR = 12'hff0;
  localparam logic [1:0] FLAGSET_NORMAL = 2'h0;
  localparam logic [1:0] FLAGSET_IRQ = 2'h1;
  localparam logic [1:0] FLAGSET_NMI = 2'h2;
  localparam int PORT_W = 6;
endpackage : irq_ctrl_pkg

// >>> test/core_model.sv
`timescale 1ns/1ns
`default_nettype none
module core_model (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Controller requests
  input wire logic vector_load,
  input wire logic [11:0] vector_addr,
  input wire logic stack_push,
  input wire logic [11:0] stack_push_data,
  input wire logic stack_pop,
  input wire logic sleep_grant,
  input wire logic wake_up,
  // Core state
  output logic [11:0] core_pc,
  output logic core_sleeping
);
  logic [11:0] stk[$];
  // Pc follows vector loads and returns; sleep follows grant and wake
  always @(posedge clk_sys) begin
    if (!rstn) begin
      core_pc <= 12'hffe;
      core_sleeping <= 1'b0;
      stk.delete();
    end else begin
      if (stack_push) stk.push_back(stack_push_data);
      if (vector_load) core_pc <= vector_addr;
      else if (stack_pop && stk.size() > 0) core_pc <= stk.pop_back();
      if (sleep_grant) core_sleeping <= 1'b1;
      else if (wake_up) core_sleeping <= 1'b0;
    end
  end
endmodule : core_model
`default_nettype wire

// >>> test/irq_ctrl_props.sv
`timescale 1ns/1ns
`default_nettype none
module irq_ctrl_props (
  // Clock and bus
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [31:0] avs_readdata,
  input wire logic avs_waitrequest,
  // Core side
  input wire logic [11:0] core_pc,
  input wire logic vector_load,
  input wire logic [11:0] vector_addr,
  input wire logic stack_push,
  input wire logic [11:0] stack_push_data,
  input wire logic suppress_next,
  input wire logic [1:0] flag_set_sel,
  input wire logic wake_up
);
  logic gen_reg;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Shadow of the global enable, taken when an option write is accepted
  always_ff @(posedge clk_sys) begin
    if (!rstn) gen_reg <= 1'b0;
    else if (avs_write && !avs_waitrequest && avs_address == 8'hc8) gen_reg <= avs_writedata[4];
  end
  chk_bus_answer: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("bus access not answered in one cycle");
  chk_option_unread: assert property (
    avs_read && avs_address == 8'hc8 && !avs_waitrequest |-> avs_readdata == 32'h0)
    else $error("option register read back");
  chk_entry_push: assert property (vector_load |-> stack_push && suppress_next)
    else $error("vector load without push or suppress");
  chk_push_pc: assert property (vector_load |-> stack_push_data == $past(core_pc))
    else $error("pushed value is not the accepted pc");
  chk_vector_legal: assert property (
    vector_load |-> vector_addr inside {12'hffc, 12'hff6, 12'hff4, 12'hff2})
    else $error("illegal vector loaded");
  chk_nmi_flags: assert property (
    vector_load && vector_addr == 12'hffc |-> flag_set_sel == 2'h2)
    else $error("nmi entry without nmi flag set");
  chk_irq_nest: assert property (
    vector_load && vector_addr != 12'hffc |-> flag_set_sel == 2'h1 && $past(flag_set_sel) == 2'h0)
    else $error("maskable entry outside normal mode");
  chk_gen_gate: assert property (
    vector_load && vector_addr != 12'hffc |-> $past(gen_reg))
    else $error("maskable entry with global enable clear");
  chk_no_wake: assert property (wake_up |-> $past(gen_reg))
    else $error("wake up with global enable clear");
  cover property (vector_load && vector_addr == 12'hffc);
  cover property (vector_load && vector_addr == 12'hff4);
  cover property (vector_load && vector_addr == 12'hff2);
endmodule : irq_ctrl_props
bind irq_ctrl irq_ctrl_props chk (.*);
`default_nettype wire

// >>> test/tb_irq_ctrl.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
  $display("BAD %s exp %0h got %0h", n, e, g); end end
module tb_irq_ctrl;
  logic clk_sys = 0, rstn = 0, avs_read = 0, avs_write = 0, nmi_pin = 1, timer_event = 0;
  logic [7:0] avs_address = 8'h00, rd;
  logic [31:0] avs_writedata = 32'h0, avs_readdata;
  logic [5:0] porta_pins = 6'h3f, portb_pins = 6'h3f;
  logic [11:0] core_pc, vector_addr, stack_push_data, va, pd, pc_q;
  logic avs_waitrequest, core_sleeping, vector_load, stack_push, stack_pop, suppress_next;
  logic wake_up, sleep_grant, vl;
  logic [1:0] flag_set_sel, fs, mode;
  logic [11:0] pcs[$];
  logic [1:0] ms[$];
  int err_total = 0, n_tests = 0, ka, kb;
  irq_ctrl dut (.*);
  core_model core (.*);
  always #4 clk_sys = ~clk_sys;
  // Verdict and end of run
  task automatic test_done();
    $display("tests %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : test_done
  // One bus access, held until waitrequest is low; results taken there
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk_sys);
      n++;
    end while (avs_waitrequest && n < 20);
    if (n >= 20) begin
      err_total++;
      test_done();
    end
    rd = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    // Core outputs launched by the accepted write stand until the next edge
    @(posedge clk_sys);
    vl = vector_load;
    va = vector_addr;
    pd = stack_push_data;
    fs = flag_set_sel;
  endtask : bus
  // Instruction boundary; e is the expected vector, zero for none
  task automatic bnd(input logic [11:0] e);
    bus(1, 8'he4, 8'h01);
    `CHK("load", e != 12'h000, vl)
    if (e != 12'h000) begin
      `CHK("vector", e, va)
      `CHK("pushed", pc_q, pd)
      pcs.push_back(pc_q);
      ms.push_back(mode);
      pc_q = e;
      mode = (e == 12'hffc) ? 2'h2 : 2'h1;
    end
    `CHK("flags", mode, fs)
  endtask : bnd
  // Return from a routine restores flag set and pc
  task automatic ret();
    bus(1, 8'he4, 8'h02);
    mode = 2'h0;
    if (pcs.size() > 0) begin
      pc_q = pcs.pop_back();
      mode = ms.pop_back();
    end
    `CHK("ret flags", mode, fs)
  endtask : ret
  // Low pulse on one port pin, or on the nmi pin when p is 2
  task automatic pulse(input int p, input int k);
    @(posedge clk_sys);
    if (p == 0) porta_pins[k] <= 1'b0;
    else if (p == 1) portb_pins[k] <= 1'b0;
    else nmi_pin <= 1'b0;
    repeat (2) @(posedge clk_sys);
    porta_pins <= 6'h3f;
    portb_pins <= 6'h3f;
    nmi_pin <= 1'b1;
    repeat (2) @(posedge clk_sys);
  endtask : pulse
  // Main sequence
  initial begin
    void'($urandom(77922));
    ka = $urandom % 6;
    kb = $urandom % 6;
    pc_q = 12'hffe;
    mode = 2'h2;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    @(negedge clk_sys);
    `CHK("reset flags", mode, flag_set_sel)
    `CHK("reset vector", 12'hffe, vector_addr)
    bus(0, 8'hc8, 8'h00);
    `CHK("option read", 8'h00, rd)
    bus(1, 8'hc8, 8'h10);
    bus(1, 8'hcc, 8'h01 << ka);
    bus(1, 8'hd4, 8'h40);
    repeat (3) pulse(0, ka);
    bnd(12'h000);
    ret();
    bnd(12'hff6);
    bnd(12'h000);
    ret();
    bnd(12'hff6);
    ret();
    bnd(12'h000);
    // Priority and nmi preemption, timer last
    @(posedge clk_sys) timer_event <= 1'b1;
    @(posedge clk_sys) timer_event <= 1'b0;
    pulse(0, ka);
    bnd(12'hff6);
    pulse(2, 0);
    bnd(12'hffc);
    bnd(12'h000);
    ret();
    ret();
    bnd(12'hff2);
    bus(1, 8'hd4, 8'h40);
    ret();
    bnd(12'h000);
    // Port B rising edge mode
    bus(1, 8'hc8, 8'h30);
    @(posedge clk_sys) portb_pins[kb] <= 1'b0;
    bus(1, 8'hcd, 8'h01 << kb);
    bnd(12'h000);
    @(posedge clk_sys) portb_pins[kb] <= 1'b1;
    repeat (2) @(posedge clk_sys);
    bnd(12'hff4);
    ret();
    // Port A level mode stores nothing
    bus(1, 8'hc8, 8'h50);
    @(posedge clk_sys) porta_pins[ka] <= 1'b0;
    bnd(12'hff6);
    ret();
    bnd(12'hff6);
    @(posedge clk_sys) porta_pins[ka] <= 1'b1;
    ret();
    bnd(12'h000);
    // Global enable clear: nmi served but no wake
    bus(1, 8'hc8, 8'h00);
    bus(1, 8'he4, 8'h04);
    pulse(2, 0);
    `CHK("wake", 1'b0, wake_up)
    bnd(12'hffc);
    ret();
    pulse(0, ka);
    bnd(12'h000);
    test_done();
  end
endmodule : tb_irq_ctrl
`default_nettype wire
